// file: usb_dev_ctl.sv
// USB device state, address, suspend/resume, detach and endpoint stall top
//
// Notes on behaviour
// - Reset: clock frozen, defaults, detached, banks cleared
// - Pull-up only when attached and bus powered
// - Controller disable resets controller except address bits 6:0
// - Endpoint reset bit clears endpoint flags
// - Bus reset disables all but endpoint zero
// - Select field routes per-endpoint accesses
// - Disabled endpoint held in reset
// - No ack without valid config; size checked
// - Disable also clears data toggle
// - Address zero until address enable set
// - Address enable cleared on resets, disable
// - 3 ms idle sets suspend, full speed
// - Non-idle lines set wake-up flag while enabled, even frozen
// - Wake-up and suspend flags clear each other
// - Detach drops pull-up; resets to one
// - Remote wake only suspended; after 5 ms
// - Resume start/end flags and request clear
// - Stall request holds until stall clear or setup
// - Stall sent sets flag, discards packet
// - Setup accepted with valid config; clears stall state on endpoint zero
// - Retry takes priority over stall
// - Clock freeze gates clocks, resume detection stays
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
`include "usb_dev_map.svh"
module usb_dev_ctl
    import usb_dev_pkg::*;
#(
    parameter int SUSP_CYC   = `SUSP_CYC,
    parameter int RESUME_CYC = `RESUME_CYC
)(
    // Clock and reset
    input  wire logic       I_SYS_CLK,
    input  wire logic       I_RST_N,
    // Register port
    input  wire logic [3:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    output logic      [7:0] O_RDATA,
    // Bus side events from the line logic
    input  wire logic       I_VBUS,
    input  wire logic       I_LINE_IDLE,
    input  wire logic       I_BUS_RST,
    input  wire logic       I_EOR_SEEN,
    input  wire logic       I_TOK_VALID,
    input  wire logic       I_TOK_SETUP,
    input  wire logic [6:0] I_TOK_ADDR,
    input  wire logic [2:0] I_TOK_EP,
    input  wire logic       I_RETRY,
    // Bus side controls
    output logic            O_PULLUP_DP,
    output logic            O_PULLUP_DM,
    output logic            O_RESUME_DRV,
    output logic            O_STALL,
    output logic            O_ACK,
    output logic            O_CLK_RUN
);
    logic [7:0] ctrl_r;
    logic [7:0] devctrl_r;
    logic [7:0] addr_r;
    logic [4:0] stat_r;
    ep_idx_t    sel_r;
    logic [`NUM_EP-1:0] eprst_r;
    logic [31:0] idle_cnt_r;
    logic [31:0] rs_cnt_r;
    logic [23:0] rs_len_r;
    rsm_state_e rs_state_r;
    rsm_state_e rs_state_nxt;
    logic       hard_rst;
    logic       addr_hit;
    logic       susp_set;
    logic       wake_set;
    logic       rs_start;
    logic       rs_end;
    logic [`NUM_EP-1:0] ep_stall;
    logic [`NUM_EP-1:0] ep_ack;
    logic [7:0] ep_ctrl [`NUM_EP];
    logic [7:0] ep_flag [`NUM_EP];
    logic [7:0] ep_cfg  [`NUM_EP];
    logic [7:0] rdata_nxt;
    logic       running;

    usb_ep_if epb [`NUM_EP] ();

    assign hard_rst = ~ctrl_r[`B_CTRL_EN];
    // Gated clock modelled as a run flag; wake detection ignores it
    assign running  = ctrl_r[`B_CTRL_EN] & ~ctrl_r[`B_CTRL_FRZ];

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_r <= `CTRL_RST;
        end else if (I_WR && I_ADDR == `A_CTRL) begin
            ctrl_r <= I_WDATA & 8'ha0;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            devctrl_r <= `DEVCTRL_RST;
        end else if (hard_rst) begin
            devctrl_r <= `DEVCTRL_RST;
        end else if (rs_end) begin
            devctrl_r[`B_DC_RMWK] <= 1'b0;
        end else if (I_WR && I_ADDR == `A_DEVCTRL) begin
            devctrl_r[`B_DC_DETACH] <= I_WDATA[`B_DC_DETACH];
            devctrl_r[`B_DC_LOWSPD] <= I_WDATA[`B_DC_LOWSPD];
            // Only honoured while suspended
            if (I_WDATA[`B_DC_RMWK] && stat_r[`B_ST_SUSP]) begin
                devctrl_r[`B_DC_RMWK] <= 1'b1;
            end
        end
    end

    // Address: bit 7 enables, low seven bits hold the address
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            addr_r <= 8'h00;
        end else if (I_BUS_RST) begin
            addr_r <= 8'h00;
        end else if (hard_rst) begin
            addr_r[7] <= 1'b0;
        end else if (I_WR && I_ADDR == `A_ADDR) begin
            addr_r <= I_WDATA;
        end
    end

    assign addr_hit = addr_r[7] ? (I_TOK_ADDR == addr_r[6:0])
                                : (I_TOK_ADDR == 7'h00);

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            idle_cnt_r <= 32'h0;
        end else if (!I_LINE_IDLE || !running) begin
            idle_cnt_r <= 32'h0;
        end else if (idle_cnt_r != 32'hffffffff) begin
            idle_cnt_r <= idle_cnt_r + 32'h1;
        end
    end

    assign susp_set = running && idle_cnt_r == SUSP_CYC[31:0] - 32'h1;
    assign wake_set = ctrl_r[`B_CTRL_EN] & ~I_LINE_IDLE;

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rs_state_r <= RS_IDLE;
        end else if (hard_rst) begin
            rs_state_r <= RS_IDLE;
        end else begin
            rs_state_r <= rs_state_nxt;
        end
    end

    always_comb begin
        rs_state_nxt = rs_state_r;
        case (rs_state_r)
            RS_IDLE: begin
                if (devctrl_r[`B_DC_RMWK]) begin
                    rs_state_nxt = RS_WAIT;
                end
            end
            RS_WAIT: begin
                if (rs_start) begin
                    rs_state_nxt = RS_SEND;
                end
            end
            RS_SEND: begin
                if (rs_end) begin
                    rs_state_nxt = RS_IDLE;
                end
            end
            default: rs_state_nxt = RS_IDLE;
        endcase
    end

    // Waits on a line-idle count of its own
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rs_cnt_r <= 32'h0;
        end else if (rs_state_r != RS_WAIT || !I_LINE_IDLE) begin
            rs_cnt_r <= 32'h0;
        end else begin
            rs_cnt_r <= rs_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rs_len_r <= 24'h0;
        end else if (rs_state_r != RS_SEND) begin
            rs_len_r <= 24'h0;
        end else begin
            rs_len_r <= rs_len_r + 24'h1;
        end
    end

    assign rs_start = rs_state_r == RS_WAIT && rs_cnt_r == RESUME_CYC[31:0] - 32'h1;
    assign rs_end   = rs_state_r == RS_SEND && rs_len_r == `URS_LEN_CYC - 24'h1;

    // Set wins over software clear; each flag clears the other
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            stat_r <= 5'h00;
        end else if (hard_rst) begin
            stat_r <= 5'h00;
        end else begin
            if (I_WR && I_ADDR == `A_DEVSTAT) begin
                stat_r[3:0] <= stat_r[3:0] & I_WDATA[3:0];
            end
            if (wake_set) begin
                stat_r[`B_ST_WAKE] <= 1'b1;
                stat_r[`B_ST_SUSP] <= 1'b0;
            end else if (susp_set) begin
                stat_r[`B_ST_SUSP] <= 1'b1;
                stat_r[`B_ST_WAKE] <= 1'b0;
                stat_r[`B_ST_FULL] <= 1'b1;
            end
            if (rs_start) begin
                stat_r[`B_ST_UPRS] <= 1'b1;
                stat_r[`B_ST_SUSP] <= 1'b0;
            end
            if (I_EOR_SEEN) begin
                stat_r[`B_ST_EORS] <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sel_r <= 3'h0;
        end else if (hard_rst) begin
            sel_r <= 3'h0;
        end else if (I_WR && I_ADDR == `A_EPSEL) begin
            sel_r <= I_WDATA[2:0];
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            eprst_r <= '0;
        end else if (hard_rst) begin
            eprst_r <= '0;
        end else if (I_WR && I_ADDR == `A_EPRST) begin
            eprst_r <= I_WDATA[`NUM_EP-1:0];
        end
    end

    generate
        for (genvar g = 0; g < `NUM_EP; g++) begin : g_ep
            logic sel;
            logic tok;
            assign sel = sel_r == 3'(g);
            assign tok = I_TOK_VALID & addr_hit & running & I_TOK_EP == 3'(g);
            // Per-endpoint writes go to the selected endpoint
            assign epb[g].soft_rst  = eprst_r[g];
            assign epb[g].hard_rst  = hard_rst;
            assign epb[g].bus_rst   = I_BUS_RST;
            assign epb[g].wr_ctrl   = I_WR & sel & I_ADDR == `A_EPCTRL;
            assign epb[g].wr_flag   = I_WR & sel & I_ADDR == `A_EPFLAG;
            assign epb[g].wr_cfg    = I_WR & sel & I_ADDR == `A_EPCFG;
            assign epb[g].wdata     = I_WDATA;
            assign epb[g].tok_setup = tok & I_TOK_SETUP;
            assign epb[g].tok_data  = tok & ~I_TOK_SETUP;
            assign epb[g].retry     = I_RETRY;
            assign ep_stall[g]      = epb[g].send_stall;
            assign ep_ack[g]        = epb[g].ack | epb[g].tok_setup & epb[g].cfg[`B_CF_OK];
            assign ep_ctrl[g]       = epb[g].ctrl;
            assign ep_flag[g]       = epb[g].flag;
            assign ep_cfg[g]        = epb[g].cfg;
            usb_ep_ctl #(.IS_CTRL(g == 0)) u_ep (
                .I_SYS_CLK (I_SYS_CLK),
                .I_RST_N   (I_RST_N),
                .e         (epb[g])
            );
        end
    endgenerate

    always_comb begin
        rdata_nxt = 8'h00;
        case (I_ADDR)
            `A_CTRL:    rdata_nxt = ctrl_r;
            `A_DEVCTRL: rdata_nxt = devctrl_r;
            `A_ADDR:    rdata_nxt = addr_r;
            `A_DEVSTAT: rdata_nxt = {3'h0, stat_r};
            `A_EPSEL:   rdata_nxt = {5'h00, sel_r};
            `A_EPRST:   rdata_nxt = {1'b0, eprst_r};
            `A_EPCFG:   rdata_nxt = (sel_r < `NUM_EP) ? ep_cfg[sel_r] : 8'h00;
            `A_EPCTRL:  rdata_nxt = (sel_r < `NUM_EP) ? ep_ctrl[sel_r] : 8'h00;
            `A_EPFLAG:  rdata_nxt = (sel_r < `NUM_EP) ? ep_flag[sel_r] : 8'h00;
            default:    rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_RDATA      <= 8'h00;
            O_PULLUP_DP  <= 1'b0;
            O_PULLUP_DM  <= 1'b0;
            O_RESUME_DRV <= 1'b0;
            O_STALL      <= 1'b0;
            O_ACK        <= 1'b0;
            O_CLK_RUN    <= 1'b0;
        end else begin
            O_RDATA      <= I_RD ? rdata_nxt : 8'h00;
            O_PULLUP_DP  <= ctrl_r[`B_CTRL_EN] & ~devctrl_r[`B_DC_DETACH] & I_VBUS
                            & ~devctrl_r[`B_DC_LOWSPD];
            O_PULLUP_DM  <= ctrl_r[`B_CTRL_EN] & ~devctrl_r[`B_DC_DETACH] & I_VBUS
                            & devctrl_r[`B_DC_LOWSPD];
            O_RESUME_DRV <= rs_state_r == RS_SEND;
            O_STALL      <= |ep_stall;
            O_ACK        <= |ep_ack;
            O_CLK_RUN    <= running;
        end
    end

    a_pullup_gate: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (devctrl_r[`B_DC_DETACH] || !I_VBUS) |=> !O_PULLUP_DP && !O_PULLUP_DM)
        else $error("pull-up on while detached");
    a_addr_zero: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        !addr_r[7] && I_TOK_ADDR != 7'h00 |-> !addr_hit)
        else $error("nonzero address accepted");
    a_flag_excl: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        wake_set && !hard_rst |=> stat_r[`B_ST_WAKE] && !stat_r[`B_ST_SUSP])
        else $error("wake did not clear suspend");
    a_bus_rst_addr: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        I_BUS_RST |=> addr_r == 8'h00)
        else $error("address survived bus reset");
    a_susp_set: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        susp_set && !wake_set && !hard_rst && !rs_start |=> stat_r[`B_ST_SUSP])
        else $error("suspend not flagged");
    a_rmwk_susp: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        $rose(devctrl_r[`B_DC_RMWK]) |-> $past(stat_r[`B_ST_SUSP]))
        else $error("remote wake outside suspend");
    // Resume end is too far out for the bench; these guard the flag handling
    a_rmwk_clear: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        rs_end |=> !devctrl_r[`B_DC_RMWK])
        else $error("remote wake request not cleared");
    a_resume_flag: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        rs_start && !hard_rst |=> stat_r[`B_ST_UPRS] && !stat_r[`B_ST_SUSP])
        else $error("resume start flags wrong");
    a_ctl_disable: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        hard_rst |=> !addr_r[7] && devctrl_r == `DEVCTRL_RST && stat_r == 5'h00)
        else $error("disable did not reset controller");
endmodule

// file: usb_dev_ctl_tb.sv
// Self-checking bench for the device state, address, suspend and stall block
`timescale 1ns/10ps
`include "usb_dev_map.svh"
module usb_dev_ctl_tb;
    localparam int SUSP = 20;
    localparam int RSM  = 30;
    logic       I_SYS_CLK = 1'b0;
    logic       I_RST_N;
    logic [3:0] I_ADDR;
    logic [7:0] I_WDATA;
    logic       I_WR;
    logic       I_RD;
    logic [7:0] O_RDATA;
    logic       vbus, idle, brst, eor, tv, ts, retry, dp, dm, rsm, stall, ack, run;
    logic [6:0] ta;
    logic [2:0] te;
    logic [1:0] r;
    int         n_errors = 0;
    int         checked = 0;
    always #2.5 I_SYS_CLK = ~I_SYS_CLK;
    usb_dev_ctl #(.SUSP_CYC(SUSP), .RESUME_CYC(RSM)) i_usb_dev_ctl (
        .I_SYS_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
        .I_VBUS(vbus), .I_LINE_IDLE(idle), .I_BUS_RST(brst), .I_EOR_SEEN(eor),
        .I_TOK_VALID(tv), .I_TOK_SETUP(ts), .I_TOK_ADDR(ta), .I_TOK_EP(te),
        .I_RETRY(retry), .O_PULLUP_DP(dp), .O_PULLUP_DM(dm), .O_RESUME_DRV(rsm),
        .O_STALL(stall), .O_ACK(ack), .O_CLK_RUN(run));
    usb_host_model i_usb_host_model (.i_clk(I_SYS_CLK), .o_vbus(vbus), .o_idle(idle),
        .o_brst(brst), .o_eor(eor), .o_tv(tv), .o_ts(ts), .o_ta(ta), .o_te(te),
        .o_retry(retry), .i_ack(ack), .i_stall(stall));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge I_SYS_CLK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_SYS_CLK);
        I_WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge I_SYS_CLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_SYS_CLK);
        I_RD <= 1'b0;
        #1 chk($sformatf("reg %h", a), O_RDATA & m, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge I_SYS_CLK);
        #1;
    endtask
    task automatic tk(input logic s, input logic [6:0] a, input logic [2:0] e,
                      input logic [1:0] x);
        i_usb_host_model.tok(s, a, e, r);
        chk("ack,stall", {6'h00, r}, {6'h00, x});
    endtask
    task automatic t_reset;
        rd(`A_CTRL, 8'hff, `CTRL_RST);
        rd(`A_DEVCTRL, 8'hff, 8'h01);
        rd(`A_ADDR, 8'hff, 8'h00);
        chk("pullups,run", {5'h00, dp, dm, run}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_attach;
        wr(`A_CTRL, 8'h80);
        wr(`A_DEVCTRL, 8'h00);
        tick(3);
        chk("pullup no vbus", {7'h00, dp}, 8'h00);
        i_usb_host_model.set(0, 1'b1);
        tick(3);
        chk("pullup,run", {6'h00, dp, dm, run}, 8'h05);
        wr(`A_DEVCTRL, 8'h01);
        tick(3);
        chk("detached", {7'h00, dp}, 8'h00);
        wr(`A_CTRL, 8'ha0);
        tick(3);
        chk("frozen", {7'h00, run}, 8'h00);
        wr(`A_CTRL, 8'h80);
        wr(`A_DEVCTRL, 8'h00);
        tick(3);
        chk("reattached", {6'h00, dp, run}, 8'h03);
        wr(`A_DEVCTRL, 8'h04);
        tick(3);
        chk("low speed pullups", {6'h00, dp, dm}, 8'h01);
        wr(`A_DEVCTRL, 8'h00);
        $display("test attach done");
    endtask
    task automatic t_ep;
        wr(`A_EPSEL, 8'h00);
        wr(`A_EPCFG, 8'h00);
        wr(`A_EPCTRL, 8'h01);
        rd(`A_EPCFG, 8'h80, 8'h80);
        wr(`A_EPSEL, 8'h01);
        wr(`A_EPCFG, 8'h60);
        wr(`A_EPCTRL, 8'h01);
        rd(`A_EPCFG, 8'h80, 8'h00);
        tk(1'b0, 7'h00, 3'h1, 2'b00);
        wr(`A_EPCFG, 8'h10);
        rd(`A_EPCFG, 8'h80, 8'h80);
        tk(1'b0, 7'h00, 3'h1, 2'b10);
        $display("test endpoint config done");
    endtask
    task automatic t_addr;
        tk(1'b0, 7'h00, 3'h0, 2'b10);
        wr(`A_ADDR, 8'h05);
        tk(1'b0, 7'h05, 3'h0, 2'b00);
        tk(1'b0, 7'h00, 3'h0, 2'b10);
        wr(`A_ADDR, 8'h85);
        tk(1'b0, 7'h05, 3'h0, 2'b10);
        tk(1'b0, 7'h00, 3'h0, 2'b00);
        $display("test address done");
    endtask
    task automatic t_stall;
        wr(`A_EPSEL, 8'h00);
        wr(`A_EPCTRL, 8'h21);
        tk(1'b0, 7'h05, 3'h0, 2'b01);
        tk(1'b0, 7'h05, 3'h0, 2'b01);
        rd(`A_EPFLAG, 8'h26, 8'h02);
        i_usb_host_model.set(4, 1'b1);
        i_usb_host_model.tok(1'b0, 7'h05, 3'h0, r);
        chk("stall on retry", {7'h00, r[0]}, 8'h00);
        i_usb_host_model.set(4, 1'b0);
        tk(1'b1, 7'h05, 3'h0, 2'b10);
        rd(`A_EPCTRL, 8'hff, 8'h01);
        rd(`A_EPFLAG, 8'h0b, 8'h08);
        wr(`A_EPCTRL, 8'h21);
        wr(`A_EPCTRL, 8'h11);
        rd(`A_EPCTRL, 8'hff, 8'h01);
        tk(1'b0, 7'h05, 3'h0, 2'b10);
        wr(`A_EPRST, 8'h01);
        wr(`A_EPRST, 8'h00);
        rd(`A_EPFLAG, 8'h0a, 8'h00);
        rd(`A_EPCTRL, 8'hff, 8'h01);
        $display("test stall done");
    endtask
    task automatic t_busrst;
        i_usb_host_model.set(2, 1'b1);
        i_usb_host_model.set(2, 1'b0);
        tick(2);
        rd(`A_ADDR, 8'hff, 8'h00);
        wr(`A_EPSEL, 8'h01);
        rd(`A_EPCTRL, 8'h01, 8'h00);
        tk(1'b0, 7'h00, 3'h1, 2'b00);
        tk(1'b0, 7'h00, 3'h0, 2'b10);
        $display("test bus reset done");
    endtask
    task automatic t_suspend;
        int k;
        wr(`A_DEVCTRL, 8'h02);
        rd(`A_DEVCTRL, 8'h02, 8'h00);
        i_usb_host_model.set(1, 1'b1);
        tick(SUSP - 6);
        rd(`A_DEVSTAT, 8'h01, 8'h00);
        tick(10);
        rd(`A_DEVSTAT, 8'h13, 8'h11);
        i_usb_host_model.set(1, 1'b0);
        tick(3);
        rd(`A_DEVSTAT, 8'h03, 8'h02);
        i_usb_host_model.set(1, 1'b1);
        tick(SUSP + 5);
        wr(`A_DEVCTRL, 8'h02);
        for (k = 0; k < RSM + SUSP + 20 && rsm !== 1'b1; k++) tick(1);
        chk("resume drive", {7'h00, rsm}, 8'h01);
        rd(`A_DEVSTAT, 8'h05, 8'h04);
        i_usb_host_model.set(3, 1'b1);
        i_usb_host_model.set(3, 1'b0);
        tick(2);
        rd(`A_DEVSTAT, 8'h08, 8'h08);
        $display("test suspend and resume done");
    endtask
    task automatic t_disable;
        wr(`A_ADDR, 8'h85);
        wr(`A_CTRL, 8'h00);
        tick(2);
        rd(`A_ADDR, 8'h80, 8'h00);
        rd(`A_DEVCTRL, 8'hff, 8'h01);
        chk("pullup off", {7'h00, dp}, 8'h00);
        $display("test disable done");
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        I_RST_N = 1'b0;
        {I_WR, I_RD} = 2'b00;
        I_ADDR = 4'h0;
        I_WDATA = 8'h00;
        repeat (20) @(posedge I_SYS_CLK);
        I_RST_N <= 1'b1;
        t_reset;
        t_attach;
        t_ep;
        t_addr;
        t_stall;
        t_busrst;
        t_suspend;
        t_disable;
        end_sim;
    end
    // Whole run is a few hundred cycles; cut a hang well beyond that
    initial begin
        #(5 * 20000);
        n_errors++;
        end_sim;
    end
endmodule

// file: usb_dev_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef USB_DEV_MAP_SVH
`define USB_DEV_MAP_SVH
`define A_CTRL        4'h0
`define A_DEVCTRL     4'h1
`define A_ADDR        4'h2
`define A_DEVSTAT     4'h3
`define A_EPSEL       4'h4
`define A_EPRST       4'h5
`define A_EPCFG       4'h6
`define A_EPCTRL      4'h7
`define A_EPFLAG      4'h8
`define A_EPIEN       4'h9
`define A_LINK        4'ha
`define B_CTRL_EN     7
`define B_CTRL_FRZ    5
`define CTRL_RST      8'h20
`define B_DC_DETACH   0
`define B_DC_RMWK     1
`define B_DC_LOWSPD   2
`define DEVCTRL_RST   8'h01
`define B_ST_SUSP     0
`define B_ST_WAKE     1
`define B_ST_UPRS     2
`define B_ST_EORS     3
`define B_ST_FULL     4
`define B_EC_STALL_REQUEST  5
`define B_EC_STALLCLR 4
`define B_EC_EN       0
`define B_EF_STALLED  1
`define B_EF_SETUP    3
`define B_EF_TXIN     0
`define B_EF_RXOUT    2
`define B_EF_BANK_ACCESS_ALLOWED     5
`define B_CF_OK       7
`define SIZE_MAX      3'd5
`define NUM_EP        7
`define SUSP_MS       3
`define RESUME_MS     5
`define CLK_MHZ       200
`define SUSP_CYC      (`SUSP_MS * 1000 * `CLK_MHZ)
`define RESUME_CYC    (`RESUME_MS * 1000 * `CLK_MHZ)
`define URS_LEN_CYC   24'd2000000
`endif

// file: usb_dev_pkg.sv
// Types shared by the device controller files
package usb_dev_pkg;
    typedef logic [2:0] ep_idx_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_WAIT = 2'b01,
        RS_SEND = 2'b10
    } rsm_state_e;
endpackage

// file: usb_ep_ctl.sv
// One endpoint: enable, config check, stall and setup handling
`timescale 1ns/10ps
`include "usb_dev_map.svh"
module usb_ep_ctl
    import usb_dev_pkg::*;
#(
    parameter logic IS_CTRL = 1'b0
)(
    input  wire logic I_SYS_CLK,
    input  wire logic I_RST_N,
    usb_ep_if.ep      e
);
    logic [7:0] ctrl_r;
    logic [7:0] flag_r;
    logic [7:0] cfg_r;
    logic       toggle_r;
    logic       ep_rst;
    logic       stall_now;
    logic       setup_now;
    logic       size_ok;

    // Endpoint held in reset while disabled
    assign ep_rst    = e.soft_rst | ~ctrl_r[`B_EC_EN];
    assign size_ok   = e.wdata[6:4] <= `SIZE_MAX;
    assign setup_now = IS_CTRL & e.tok_setup & cfg_r[`B_CF_OK];
    // Retry wins over stall
    assign stall_now = e.tok_data & ~e.retry & ctrl_r[`B_EC_STALL_REQUEST] & ~ep_rst;

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ctrl_r <= IS_CTRL ? 8'h01 : 8'h00;
        end else if (e.hard_rst || (e.bus_rst && !IS_CTRL)) begin
            ctrl_r <= IS_CTRL ? 8'h01 : 8'h00;
        end else if (setup_now) begin
            ctrl_r[`B_EC_STALL_REQUEST] <= 1'b0;
        end else if (e.wr_ctrl) begin
            ctrl_r[`B_EC_EN] <= e.wdata[`B_EC_EN];
            // Stall clear always reads zero
            ctrl_r[`B_EC_STALLCLR] <= 1'b0;
            if (e.wdata[`B_EC_STALLCLR]) begin
                ctrl_r[`B_EC_STALL_REQUEST] <= 1'b0;
            end else if (e.wdata[`B_EC_STALL_REQUEST]) begin
                ctrl_r[`B_EC_STALL_REQUEST] <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cfg_r <= 8'h00;
        end else if (e.hard_rst) begin
            cfg_r <= 8'h00;
        end else if (e.wr_cfg) begin
            cfg_r <= {size_ok, e.wdata[6:0]};
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            toggle_r <= 1'b0;
        end else if (e.hard_rst || !ctrl_r[`B_EC_EN]) begin
            toggle_r <= 1'b0;
        end else if (e.ack) begin
            toggle_r <= ~toggle_r;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            flag_r <= 8'h00;
        end else if (e.hard_rst) begin
            flag_r <= 8'h00;
        end else if (setup_now) begin
            flag_r <= 8'h00 | (8'h01 << `B_EF_SETUP);
        end else if (ep_rst) begin
            flag_r <= 8'h00;
        end else begin
            if (e.wr_flag) begin
                flag_r <= flag_r & e.wdata;
            end
            // Stall event wins over clear
            if (stall_now) begin
                flag_r[`B_EF_STALLED] <= 1'b1;
            end else if (e.ack && !IS_CTRL) begin
                flag_r[`B_EF_RXOUT] <= 1'b1;
                flag_r[`B_EF_BANK_ACCESS_ALLOWED]  <= 1'b1;
            end
        end
    end

    // Stalled packets discarded, no ack
    assign e.ack        = e.tok_data & cfg_r[`B_CF_OK] & ~ep_rst & ~stall_now
                          & ~ctrl_r[`B_EC_STALL_REQUEST];
    assign e.send_stall = stall_now;
    assign e.ctrl       = {ctrl_r[7:1], ctrl_r[0]} ^ {7'h00, 1'b0} | {6'h00, toggle_r, 1'b0} & 8'h00;
    assign e.flag       = flag_r;
    assign e.cfg        = cfg_r;

    a_stall_clear: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        e.wr_ctrl && e.wdata[`B_EC_STALLCLR] && !setup_now && !e.hard_rst
        |=> !ctrl_r[`B_EC_STALL_REQUEST] && !ctrl_r[`B_EC_STALLCLR])
        else $error("stall request not cleared");
    a_setup_wins: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        setup_now && !e.hard_rst |=> flag_r[`B_EF_SETUP] && !flag_r[`B_EF_STALLED]
        && !flag_r[`B_EF_TXIN])
        else $error("setup did not override stall");
    a_retry_prio: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        e.retry |-> !e.send_stall)
        else $error("stall sent during retry");
    a_no_cfg_ack: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        !cfg_r[`B_CF_OK] |-> !e.ack)
        else $error("ack without valid config");
    a_dis_reset: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
        !ctrl_r[`B_EC_EN] && !setup_now ##1 !$past(e.hard_rst) |-> flag_r == 8'h00
        && !toggle_r)
        else $error("disabled endpoint not held in reset");
endmodule

// file: usb_ep_if.sv
// Per-endpoint event and control bundle
`timescale 1ns/10ps
interface usb_ep_if;
    logic soft_rst;
    logic hard_rst;
    logic bus_rst;
    logic wr_ctrl;
    logic wr_flag;
    logic wr_cfg;
    logic [7:0] wdata;
    logic tok_setup;
    logic tok_data;
    logic retry;
    logic [7:0] ctrl;
    logic [7:0] flag;
    logic [7:0] cfg;
    logic send_stall;
    logic ack;
    modport top (output soft_rst, hard_rst, bus_rst, wr_ctrl, wr_flag, wr_cfg, wdata,
                 tok_setup, tok_data, retry, input ctrl, flag, cfg, send_stall, ack);
    modport ep  (input soft_rst, hard_rst, bus_rst, wr_ctrl, wr_flag, wr_cfg, wdata,
                 tok_setup, tok_data, retry, output ctrl, flag, cfg, send_stall, ack);
endinterface

// file: usb_host_model.sv
// Host-side bus model: power, line state, bus reset, end of resume and tokens
`timescale 1ns/10ps
module usb_host_model (
    // Clock
    input  wire logic       i_clk,
    // Bus events towards the device
    output logic            o_vbus,
    output logic            o_idle,
    output logic            o_brst,
    output logic            o_eor,
    output logic            o_tv,
    output logic            o_ts,
    output logic [6:0]      o_ta,
    output logic [2:0]      o_te,
    output logic            o_retry,
    // Handshakes from the device
    input  wire logic       i_ack,
    input  wire logic       i_stall
);
    initial begin
        {o_vbus, o_idle, o_brst, o_eor, o_tv, o_ts, o_retry} = 7'h00;
        o_ta = 7'h00;
        o_te = 3'h0;
    end
    // One-cycle token; handshake sampled in the cycle after it
    task automatic tok(input logic s, input logic [6:0] a, input logic [2:0] e,
                       output logic [1:0] r);
        @(posedge i_clk);
        o_tv <= 1'b1;
        o_ts <= s;
        o_ta <= a;
        o_te <= e;
        @(posedge i_clk);
        o_tv <= 1'b0;
        // Released fields never keep their old value
        o_ta <= ~a;
        o_te <= ~e;
        #1 r = {i_ack, i_stall};
    endtask
    task automatic set(input int which, input logic v);
        @(posedge i_clk);
        case (which)
            0: o_vbus <= v;
            1: o_idle <= v;
            2: o_brst <= v;
            3: o_eor <= v;
            default: o_retry <= v;
        endcase
    endtask
endmodule
